/* shared/scec_pkg.sv */
// package: command byte layout, enable bits, timing for the sensor command block
package scec_pkg;
   // command byte fields
   localparam int          CMD_FLAG_BIT   = 7;
   localparam int          TYPE_HI        = 6;
   localparam int          TYPE_LO        = 5;
   localparam int          CODE_HI        = 4;
   localparam int          CODE_LO        = 0;
   localparam logic [1:0]  TYPE_REPEAT    = 2'h0;
   localparam logic [1:0]  TYPE_AUTOINC   = 2'h1;
   localparam logic [1:0]  TYPE_RESERVED  = 2'h2;
   localparam logic [1:0]  TYPE_SPECIAL   = 2'h3;
   localparam logic [4:0]  SF_IRQ_CLEAR   = 5'h06;
   // enable register
   localparam logic [4:0]  ENABLE_ADDR    = 5'h00;
   localparam int          EN_OSC_BIT     = 0;
   localparam int          EN_CONV_BIT    = 1;
   localparam int          EN_WAIT_BIT    = 3;
   localparam int          EN_IRQ_BIT     = 4;
   localparam logic [7:0]  ENABLE_WMASK   = 8'h1b;
   localparam logic [7:0]  ENABLE_RESET   = 8'h00;
   localparam logic [7:0]  CMD_RESET      = 8'h00;
   // warm-up after power-on
   localparam int          CLK_HZ         = 50000000;
   localparam int          WARMUP_US      = 2400;
   localparam int          WARMUP_CYC     = (CLK_HZ / 1000000) * WARMUP_US;
   localparam int          WCNT_W         = 17;
   // controller registers (byte offsets on axi4-lite)
   localparam logic [7:0]  R_CMD          = 8'h00;
   localparam logic [7:0]  R_DATA         = 8'h04;
   localparam logic [7:0]  R_STATUS       = 8'h08;
   localparam logic [7:0]  R_IRQ_STAT     = 8'h0c;
   localparam logic [7:0]  R_IRQ_MASK     = 8'h10;
   localparam logic [1:0]  RESP_OKAY      = 2'h0;
   localparam logic [1:0]  RESP_SLVERR    = 2'h2;
endpackage

/* shared/scec_if.sv */
// interface: byte link between controller and sensor command block
`timescale 1ns/10ps
interface scec_if;
   logic       wr_valid;
   logic [7:0] wr_byte;
   logic       rd_req;
   logic       rd_valid;
   logic [7:0] rd_byte;
   logic       irq;
   modport device (input wr_valid, input wr_byte, input rd_req,
                   output rd_valid, output rd_byte, output irq);
   modport ctrl   (output wr_valid, output wr_byte, output rd_req,
                   input rd_valid, input rd_byte, input irq);
endinterface

/* hw/scec_device.sv */
// sensor end: command byte decoder, address pointer, enable register, warm-up
// Summary of operation
// RULE1: host sets bit 7 on command bytes
// RULE2: bits 6:5 pick repeat, increment or special
// RULE3: repeat mode keeps the address pointer fixed
// RULE4: increment mode advances pointer after each byte
// RULE5: bits 4:0 are address or special code
// RULE6: code 00110 clears pending interrupt, self-clearing
// RULE7: host writes no other special code
// RULE8: enable bit 4 allows conversion interrupts
// RULE9: enable bit 3 switches wait timer
// RULE10: enable bit 1 switches colour conversion
// RULE11: enable bit 0 switches oscillator, gates timers
// RULE12: no conversion until 2.4 ms after power-on
// RULE13: host writes zero to reserved enable bits
// RULE14: data and reads use held address pointer (in increment mode reg_addr has already advanced when reg_we pulses)
// RULE15: interrupt holds until the clear command
// RULE16: reserved types and codes change nothing
`timescale 1ns/10ps
module scec_device (
   // clock, reset, enable
   input  wire logic       aclk,
   input  wire logic       aresetn,
   input  wire logic       ce,
   // link from controller
   scec_if.device          lnk,
   // device core side
   input  wire logic       conv_done,
   input  wire logic [7:0] reg_rdata,
   output logic            osc_on,
   output logic            wait_on,
   output logic            conv_run,
   output logic [4:0]      reg_addr,
   output logic            reg_we,
   output logic [7:0]      reg_wdata,
   output logic            irq_clear
);
   logic [7:0]               enable_q;
   logic [4:0]               ptr_q;
   logic                     autoinc_q;
   logic                     irq_q;
   logic [scec_pkg::WCNT_W-1:0] wcnt_q;
   logic                     warm_q;
   logic                     rd_valid_q;
   logic [7:0]               rd_byte_q;
   logic                     we_q;
   logic [7:0]               wdata_q;
   logic                     clr_q;

   wire       is_cmd   = lnk.wr_valid & lnk.wr_byte[scec_pkg::CMD_FLAG_BIT];       // RULE1
   wire [1:0] typ      = lnk.wr_byte[scec_pkg::TYPE_HI:scec_pkg::TYPE_LO];         // RULE2
   wire [4:0] code     = lnk.wr_byte[scec_pkg::CODE_HI:scec_pkg::CODE_LO];         // RULE5
   wire       cmd_addr = is_cmd & (typ == scec_pkg::TYPE_REPEAT |
                                   typ == scec_pkg::TYPE_AUTOINC);
   wire       cmd_clr  = is_cmd & typ == scec_pkg::TYPE_SPECIAL &
                         code == scec_pkg::SF_IRQ_CLEAR;                           // RULE6
   wire       is_data  = lnk.wr_valid & ~lnk.wr_byte[scec_pkg::CMD_FLAG_BIT];
   wire       data_acc = is_data | lnk.rd_req;
   wire       wr_en    = is_data & ptr_q == scec_pkg::ENABLE_ADDR;
   wire       osc      = enable_q[scec_pkg::EN_OSC_BIT];
   // conversion waits for oscillator and warm-up
   wire       run      = osc & enable_q[scec_pkg::EN_CONV_BIT] & warm_q;           // RULE12
   wire       irq_set  = conv_done & run & enable_q[scec_pkg::EN_IRQ_BIT];         // RULE8
   wire [7:0] rd_mux   = (ptr_q == scec_pkg::ENABLE_ADDR) ? enable_q : reg_rdata;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         enable_q   <= scec_pkg::ENABLE_RESET;
         ptr_q      <= 5'h00;
         autoinc_q  <= 1'b0;
         irq_q      <= 1'b0;
         wcnt_q     <= '0;
         warm_q     <= 1'b0;
         rd_valid_q <= 1'b0;
         rd_byte_q  <= 8'h00;
         we_q       <= 1'b0;
         wdata_q    <= 8'h00;
         clr_q      <= 1'b0;
      end else if (ce) begin
         // reserved bits forced to zero regardless of host
         if (wr_en) begin
            enable_q <= lnk.wr_byte & scec_pkg::ENABLE_WMASK;                      // RULE9
         end
         // typ 10 and unknown special codes fall through untouched
         if (cmd_addr) begin
            ptr_q     <= code;                                                     // RULE16
            autoinc_q <= typ == scec_pkg::TYPE_AUTOINC;
         end else if (data_acc && autoinc_q) begin
            ptr_q <= ptr_q + 5'h01;                                                // RULE4
         end                                                                       // RULE3
         // set wins over clear so no event is lost
         if (irq_set) begin
            irq_q <= 1'b1;
         end else if (cmd_clr) begin
            irq_q <= 1'b0;                                                         // RULE15
         end
         clr_q <= cmd_clr;                                                         // RULE6
         // warm-up restarts every time the oscillator is switched on
         if (!osc) begin
            wcnt_q <= '0;                                                          // RULE11
            warm_q <= 1'b0;
         end else if (!warm_q) begin
            if (wcnt_q == scec_pkg::WCNT_W'(scec_pkg::WARMUP_CYC - 1)) begin
               warm_q <= 1'b1;                                                     // RULE12
            end
            wcnt_q <= wcnt_q + 1'b1;
         end
         rd_valid_q <= lnk.rd_req;
         if (lnk.rd_req) begin
            rd_byte_q <= rd_mux;                                                   // RULE14
         end
         we_q    <= is_data;                                                       // RULE14
         wdata_q <= lnk.wr_byte;
      end
   end

   assign lnk.rd_valid = rd_valid_q;
   assign lnk.rd_byte  = rd_byte_q;
   assign lnk.irq      = irq_q;
   assign osc_on       = osc;
   assign wait_on      = osc & enable_q[scec_pkg::EN_WAIT_BIT];                     // RULE9
   assign conv_run     = run;                                                      // RULE10
   assign reg_addr     = ptr_q;
   assign reg_we       = we_q;
   assign reg_wdata    = wdata_q;
   assign irq_clear    = clr_q;
endmodule

/* hw/scec_ctrl.sv */
// controller end: axi4-lite registers driving byte writes and reads on the link
//
// Design decision made here: the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
module scec_ctrl (
   // clock, reset, enable
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic        ce,
   // axi4-lite slave
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   // interrupt
   output logic             irq_out,
   // link
   scec_if.ctrl             lnk
);
   logic [7:0]  aw_q;
   logic        aw_ok_q;
   logic [31:0] w_q;
   logic [3:0]  ws_q;
   logic        w_ok_q;
   logic        bvalid_q;
   logic [1:0]  bresp_q;
   logic        rvalid_q;
   logic [31:0] rdata_q;
   logic [1:0]  rresp_q;
   logic        wrv_q;
   logic [7:0]  wrb_q;
   logic        rdreq_q;
   logic        busy_q;
   logic [7:0]  rdbyte_q;
   logic [1:0]  ist_q;
   logic [1:0]  imask_q;
   logic        irq_d1_q;

   wire do_wr  = aw_ok_q & w_ok_q & ~bvalid_q & ce;
   wire do_rd  = s_axi_arvalid & ~rvalid_q & ce;
   wire a_cmd  = aw_q == scec_pkg::R_CMD;
   wire a_dat  = aw_q == scec_pkg::R_DATA;
   wire a_ist  = aw_q == scec_pkg::R_IRQ_STAT;
   wire a_msk  = aw_q == scec_pkg::R_IRQ_MASK;
   wire wr_hit = a_cmd | a_dat | a_ist | a_msk;
   wire lane0  = ws_q[0];
   // a byte is sent from cmd (bit 7 forced, see below) or data with bit 7 clear
   wire send   = do_wr & lane0 & (a_cmd | a_dat) & ~busy_q;
   wire r_dat  = s_axi_araddr == scec_pkg::R_DATA;
   wire rd_go  = do_rd & r_dat & ~busy_q;
   wire irq_rise = lnk.irq & ~irq_d1_q;
   wire rd_done  = lnk.rd_valid;
   wire [1:0] ev = {rd_done, irq_rise};
   logic [31:0] rmux;
   logic        rhit;

   always_comb begin
      rmux = 32'h0000_0000;
      rhit = 1'b1;
      unique case (s_axi_araddr)
         scec_pkg::R_DATA:     rmux = {24'h000000, rdbyte_q};
         scec_pkg::R_STATUS:   rmux = {29'h0, busy_q, lnk.irq, irq_out};
         scec_pkg::R_IRQ_STAT: rmux = {30'h0, ist_q};
         scec_pkg::R_IRQ_MASK: rmux = {30'h0, imask_q};
         scec_pkg::R_CMD:      rmux = 32'h0000_0000;
         default:              rhit = 1'b0;
      endcase
   end

   assign s_axi_awready = ~aw_ok_q & ce;
   assign s_axi_wready  = ~w_ok_q & ce;
   // a data read waits while a link read is still out, so link reads never overlap
   assign s_axi_arready = do_rd & (~r_dat | ~busy_q);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_q     <= 8'h00;
         aw_ok_q  <= 1'b0;
         w_q      <= 32'h0;
         ws_q     <= 4'h0;
         w_ok_q   <= 1'b0;
         bvalid_q <= 1'b0;
         bresp_q  <= scec_pkg::RESP_OKAY;
         rvalid_q <= 1'b0;
         rdata_q  <= 32'h0;
         rresp_q  <= scec_pkg::RESP_OKAY;
         wrv_q    <= 1'b0;
         wrb_q    <= scec_pkg::CMD_RESET;
         rdreq_q  <= 1'b0;
         busy_q   <= 1'b0;
         rdbyte_q <= 8'h00;
         ist_q    <= 2'h0;
         imask_q  <= 2'h0;
         irq_d1_q <= 1'b0;
      end else if (ce) begin
         irq_d1_q <= lnk.irq;
         wrv_q    <= 1'b0;
         rdreq_q  <= 1'b0;
         if (s_axi_awvalid && !aw_ok_q) begin
            aw_q    <= s_axi_awaddr;
            aw_ok_q <= 1'b1;
         end
         if (s_axi_wvalid && !w_ok_q) begin
            w_q    <= s_axi_wdata;
            ws_q   <= s_axi_wstrb;
            w_ok_q <= 1'b1;
         end
         if (do_wr && (send || !(lane0 && (a_cmd || a_dat)))) begin
            aw_ok_q  <= 1'b0;
            w_ok_q   <= 1'b0;
            bvalid_q <= 1'b1;
            bresp_q  <= wr_hit ? scec_pkg::RESP_OKAY : scec_pkg::RESP_SLVERR;
         end
         if (send) begin
            wrv_q <= 1'b1;
            // command bytes always carry the flag; data bytes never do
            wrb_q <= a_cmd ? (w_q[7:0] | 8'h80) : (w_q[7:0] & 8'h7f);              // RULE1
         end
         if (do_wr && lane0 && a_msk) begin
            imask_q <= w_q[1:0];
         end
         if (bvalid_q && s_axi_bready) begin
            bvalid_q <= 1'b0;
         end
         if (rd_go) begin
            rdreq_q <= 1'b1;                                                       // RULE14
            busy_q  <= 1'b1;
         end else if (rd_done) begin
            busy_q   <= 1'b0;
            rdbyte_q <= lnk.rd_byte;
         end
         if (s_axi_arready) begin
            rvalid_q <= 1'b1;
            rdata_q  <= rmux;
            rresp_q  <= rhit ? scec_pkg::RESP_OKAY : scec_pkg::RESP_SLVERR;
         end else if (rvalid_q && s_axi_rready) begin
            rvalid_q <= 1'b0;
         end
         // set wins over write-one-to-clear
         ist_q <= (ist_q & ~((do_wr && lane0 && a_ist) ? w_q[1:0] : 2'h0)) | ev;
      end
   end

   assign s_axi_bvalid = bvalid_q;
   assign s_axi_bresp  = bresp_q;
   assign s_axi_rvalid = rvalid_q;
   assign s_axi_rdata  = rdata_q;
   assign s_axi_rresp  = rresp_q;
   assign irq_out      = |(ist_q & imask_q);
   assign lnk.wr_valid = wrv_q;
   assign lnk.wr_byte  = wrb_q;
   assign lnk.rd_req   = rdreq_q;
endmodule

/* tb/scec_checker.sv */
// checker: link-level properties between controller end and sensor end
`timescale 1ns/10ps
module scec_checker (
   // clock and reset
   input wire logic       aclk,
   input wire logic       aresetn,
   // link
   input wire logic       wr_valid,
   input wire logic [7:0] wr_byte,
   input wire logic       rd_req,
   input wire logic       rd_valid,
   input wire logic [7:0] rd_byte,
   input wire logic       irq
);
   wire clr_cmd = wr_valid && wr_byte == {1'b1, scec_pkg::TYPE_SPECIAL, scec_pkg::SF_IRQ_CLEAR};
   wire bad_sf  = wr_valid && wr_byte[7:5] == 3'h7 && !clr_cmd;
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   property p_rd_answer; rd_req |=> rd_valid; endproperty
   a_rd_answer: assert property (p_rd_answer) else $error("read got no answer");
   property p_rd_cause; rd_valid |-> $past(rd_req); endproperty
   a_rd_cause: assert property (p_rd_cause) else $error("answer without read");
   property p_rd_hold; !rd_valid |-> $stable(rd_byte); endproperty
   a_rd_hold: assert property (p_rd_hold) else $error("read byte moved idle");
   property p_rd_pulse; rd_valid && !rd_req |=> !rd_valid; endproperty
   a_rd_pulse: assert property (p_rd_pulse) else $error("answer too long");
   property p_rd_single; rd_req |=> !rd_req; endproperty
   a_rd_single: assert property (p_rd_single) else $error("reads overlap");
   property p_wr_single; wr_valid |=> !wr_valid; endproperty
   a_wr_single: assert property (p_wr_single) else $error("writes overlap");
   property p_irq_hold; irq && !clr_cmd |=> irq; endproperty
   a_irq_hold: assert property (p_irq_hold) else $error("irq dropped early");
   property p_sf_ignore; bad_sf && irq |=> irq [*2]; endproperty
   a_sf_ignore: assert property (p_sf_ignore) else $error("reserved code acted");
endmodule

/* tb/sensor_command_enable_ctrl_bench.sv */
// bench: axi4-lite sequences through both ends of the sensor command link
`timescale 1ns/10ps
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin bad_count++; \
   $display("Error at %0t: got %h expected %h", $time, (a), (e)); end end
module sensor_command_enable_ctrl_bench;
   logic        aclk, aresetn, ce, conv_done, awvalid, wvalid, bready, arvalid, rready, m0;
   logic [7:0]  reg_rdata, awaddr, araddr;
   logic [31:0] wdata, v;
   logic [3:0]  wstrb;
   wire         awready, wready, bvalid, arready, rvalid, irq_out, osc_on, wait_on, conv_run;
   wire  [1:0]  bresp, rresp;
   wire  [31:0] rdata;
   wire  [4:0]  reg_addr;
   int          bad_count, check_count, clr_count, we_count;
   logic [7:0]  wd_last;
   wire         reg_we, irq_clear;
   wire  [7:0]  reg_wdata;
   scec_if lnk ();
   scec_ctrl u_scec_ctrl (.aclk(aclk), .aresetn(aresetn), .ce(ce), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .irq_out(irq_out), .lnk(lnk));
   scec_device u_scec_device (.aclk(aclk), .aresetn(aresetn), .ce(ce), .lnk(lnk),
      .conv_done(conv_done), .reg_rdata(reg_rdata), .osc_on(osc_on), .wait_on(wait_on),
      .conv_run(conv_run), .reg_addr(reg_addr), .reg_we(reg_we), .reg_wdata(reg_wdata),
      .irq_clear(irq_clear));
   scec_checker u_scec_checker (.aclk(aclk), .aresetn(aresetn), .wr_valid(lnk.wr_valid),
      .wr_byte(lnk.wr_byte), .rd_req(lnk.rd_req), .rd_valid(lnk.rd_valid),
      .rd_byte(lnk.rd_byte), .irq(lnk.irq));
   // core-side strobes last one cycle, so they are counted as they pass
   always @(posedge aclk) begin
      if (reg_we) begin
         we_count++;
         wd_last = reg_wdata;
      end
      if (irq_clear) clr_count++;
   end
   task automatic conclude();
      if (bad_count == 0 && check_count > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   // settle on a falling edge so outputs are sampled away from the launch edge
   task automatic settle();
      repeat (3) @(posedge aclk);
      @(negedge aclk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      @(posedge aclk);
      awaddr <= a;
      awvalid <= 1'b1;
      wdata <= d;
      wstrb <= 4'hf;
      wvalid <= 1'b1;
      bready <= 1'b1;
      forever begin
         @(posedge aclk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
         if (bvalid) begin
            `CHK(bresp, er)
            bready <= 1'b0;
            break;
         end
      end
      settle();
   endtask
   task automatic rd(input logic [7:0] a, input logic [1:0] er, output logic [31:0] d);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      forever begin
         @(posedge aclk);
         if (arready) arvalid <= 1'b0;
         if (rvalid) begin
            `CHK(rresp, er)
            d = rdata;
            rready <= 1'b0;
            break;
         end
      end
      settle();
   endtask
   task automatic send(input logic [7:0] a, input logic [7:0] b);
      wr(a, {24'h0, b}, scec_pkg::RESP_OKAY);
   endtask
   task automatic pulse();
      @(posedge aclk);
      conv_done <= 1'b1;
      @(posedge aclk);
      conv_done <= 1'b0;
      settle();
   endtask
   initial begin
      aclk = 1'b0;
      forever #10 aclk = ~aclk;
   end
   // watchdog spans the warm-up wait plus all bus traffic
   initial begin
      repeat (125000) @(posedge aclk);
      bad_count++;
      conclude();
   end
   initial begin
      {aresetn, conv_done, awvalid, wvalid, bready, arvalid, rready} = 7'h00;
      {awaddr, araddr, wdata, wstrb} = 52'h0;
      ce = 1'b1;
      reg_rdata = 8'h5a;
      repeat (4) @(posedge aclk);
      aresetn <= 1'b1;
      settle();
      rd(scec_pkg::R_STATUS, scec_pkg::RESP_OKAY, v);
      `CHK(v, 32'h0)
      `CHK(reg_addr, 5'h00)
      rd(8'h14, scec_pkg::RESP_SLVERR, v);
      wr(8'h18, 32'h0, scec_pkg::RESP_SLVERR);
      send(scec_pkg::R_CMD, 8'h20);
      send(scec_pkg::R_DATA, 8'hef);
      `CHK({osc_on, wait_on, conv_run}, 3'h6)
      `CHK(reg_addr, 5'h01)
      `CHK(we_count, 1)
      `CHK(wd_last, 8'h6f)
      send(scec_pkg::R_CMD, 8'h00);
      rd(scec_pkg::R_DATA, scec_pkg::RESP_OKAY, v);
      rd(scec_pkg::R_DATA, scec_pkg::RESP_OKAY, v);
      `CHK(v[7:0], 8'h0b)
      `CHK(reg_addr, 5'h00)
      repeat (scec_pkg::WARMUP_CYC) @(posedge aclk);
      settle();
      `CHK(conv_run, 1'b1)
      pulse();
      rd(scec_pkg::R_STATUS, scec_pkg::RESP_OKAY, v);
      `CHK(v[1], 1'b0)
      send(scec_pkg::R_DATA, 8'h13);
      `CHK(wait_on, 1'b0)
      `CHK(we_count, 2)
      `CHK(wd_last, 8'h13)
      pulse();
      rd(scec_pkg::R_STATUS, scec_pkg::RESP_OKAY, v);
      `CHK(v[1], 1'b1)
      send(scec_pkg::R_CMD, 8'h25);
      `CHK(reg_addr, 5'h05)
      send(scec_pkg::R_CMD, 8'h65);
      send(scec_pkg::R_CMD, 8'h47);
      `CHK(reg_addr, 5'h05)
      `CHK(we_count, 2)
      `CHK(clr_count, 0)
      rd(scec_pkg::R_IRQ_STAT, scec_pkg::RESP_OKAY, v);
      `CHK(v[0], 1'b1)
      // a set mask bit lets its status bit through to irq_out
      wr(scec_pkg::R_IRQ_MASK, 32'h0, scec_pkg::RESP_OKAY);
      m0 = irq_out;
      `CHK(m0, 1'b0)
      wr(scec_pkg::R_IRQ_MASK, 32'h3, scec_pkg::RESP_OKAY);
      `CHK(irq_out !== m0, 1'b1)
      `CHK(irq_out, 1'b1)
      wr(scec_pkg::R_IRQ_STAT, 32'h3, scec_pkg::RESP_OKAY);
      rd(scec_pkg::R_IRQ_STAT, scec_pkg::RESP_OKAY, v);
      `CHK(v[1:0], 2'h0)
      `CHK(irq_out, 1'b0)
      send(scec_pkg::R_CMD, 8'h66);
      rd(scec_pkg::R_STATUS, scec_pkg::RESP_OKAY, v);
      `CHK(v[1], 1'b0)
      `CHK(clr_count, 1)
      // with the clock enable low a finished conversion must leave no trace
      @(posedge aclk);
      ce <= 1'b0;
      pulse();
      `CHK(lnk.irq, 1'b0)
      @(posedge aclk);
      ce <= 1'b1;
      send(scec_pkg::R_CMD, 8'h23);
      rd(scec_pkg::R_DATA, scec_pkg::RESP_OKAY, v);
      `CHK(reg_addr, 5'h04)
      rd(scec_pkg::R_DATA, scec_pkg::RESP_OKAY, v);
      `CHK(v[7:0], 8'h5a)
      `CHK(reg_addr, 5'h05)
      send(scec_pkg::R_CMD, 8'h00);
      send(scec_pkg::R_DATA, 8'h00);
      `CHK({osc_on, conv_run}, 2'h0)
      conclude();
   end
endmodule
